// *** logic/pls_pkg.sv ***
// Constants for the per-port physical-layer link status register group.
// Assumes a configuration request port in the core clock domain.
package pls_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [11:0] PLS_OFS_LINK_STATUS  = 12'h538;
  localparam logic [11:0] PLS_OFS_TRAIN_STATE  = 12'h540;
  localparam logic [11:0] PLS_OFS_SEED         = 12'h55C;
  // ==========================================================
  // Field positions
  localparam int          PLS_OUTCOME_LSB      = 12;
  localparam int          PLS_PARTNER_BIT      = 16;
  localparam int          PLS_RETRAIN_BIT      = 31;
  // ==========================================================
  // Reset values, outcome codes and width limit
  localparam logic [15:0] PLS_SEED_RESET       = 16'hFFFF;
  localparam logic [1:0]  PLS_OUTCOME_IDLE     = 2'h0;
  localparam logic [1:0]  PLS_OUTCOME_SUCCESS  = 2'h1;
  localparam logic [1:0]  PLS_OUTCOME_SHORT    = 2'h2;
  localparam logic [1:0]  PLS_OUTCOME_FAILED   = 2'h3;
  localparam logic [2:0]  PLS_WIDTH_MAX        = 3'h7;
  // ==========================================================
  // Training state codes
  localparam logic [4:0]  PLS_ST_DET_QUIET     = 5'h02;
  localparam logic [4:0]  PLS_ST_DET_ACTIVE    = 5'h03;
  localparam logic [4:0]  PLS_ST_POLL_ACTIVE   = 5'h04;
  localparam logic [4:0]  PLS_ST_REC_LOCK      = 5'h10;
  localparam logic [4:0]  PLS_ST_REC_SPEED     = 5'h13;
  localparam logic [4:0]  PLS_ST_ACTIVE        = 5'h14;
  localparam logic [4:0]  PLS_ST_DISABLED      = 5'h1A;
  localparam logic [4:0]  PLS_ST_HOT_RESET     = 5'h1B;
  // Retrain sequencer states, Gray from IDLE to GO
  typedef enum logic [1:0]
  {
    PLS_RT_IDLE = 2'b00,
    PLS_RT_ACK  = 2'b01,
    PLS_RT_GO   = 2'b11
  } pls_rt_type;
endpackage : pls_pkg

// *** logic/pls_seed_counter.sv ***
// Pseudo-random sequence generator for crosslink operation.
// Assumes the caller pulses the load input whenever the seed changes.
`timescale 1ns/1ps
module pls_seed_counter
  import pls_pkg::*;
(
  input  wire logic        i_clk_sys,  // Core clock
  input  wire logic        i_srst,     // Sync reset, sticky domain
  input  wire logic        i_load,     // Reload from seed
  input  wire logic        i_step,     // Advance one step
  input  wire logic [15:0] i_seed,     // Seed value
  output logic      [15:0] o_value     // Current sequence word
);
  // ==========================================================
  // State
  typedef struct packed
  {
    logic [15:0] lfsr;                 // Shift register
  } pls_sc_type;
  pls_sc_type st_reg;                  // Registered state
  pls_sc_type st_next;                 // Next state

  // Load wins over step so a new seed restarts cleanly
  always_comb
  begin
    st_next = st_reg;
    if (i_load)
    begin
      st_next.lfsr = i_seed;
    end
    else if (i_step)
    begin
      // x16+x5+x4+x3+1 taps
      st_next.lfsr = {st_reg.lfsr[14:0],
                      st_reg.lfsr[15] ^ st_reg.lfsr[4] ^ st_reg.lfsr[3] ^ st_reg.lfsr[2]};
    end
  end

  // Register update
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      st_reg.lfsr <= PLS_SEED_RESET;
    else
      st_reg <= st_next;
  end

  assign o_value = st_reg.lfsr;

  // ==========================================================
  // Checks
  property p_seed_reload;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_load |=> (o_value == $past(i_seed));
  endproperty
  a_seed_reload: assert property (p_seed_reload) else $error("seed not reloaded");
endmodule : pls_seed_counter

// *** logic/pls_regs.sv ***
// Physical-layer link status, training state and seed registers.
// Assumes config requests arrive as one-cycle strobes in the core domain,
// and that the training machine and width logic sit outside this block.
`timescale 1ns/1ps
module pls_regs
  import pls_pkg::*;
(
  input  wire logic        i_clk_sys,        // Core clock, 10 MHz
  input  wire logic        i_srst,           // Non-sticky reset
  input  wire logic        i_srst_sticky,    // Sticky (power-on) reset
  input  wire logic        i_cfg_req,        // Config request strobe
  input  wire logic        i_cfg_wr,         // 1 write, 0 read
  input  wire logic [11:0] i_cfg_addr,       // Byte offset
  input  wire logic [31:0] i_cfg_wdata,      // Write data
  input  wire logic [3:0]  i_cfg_be,         // Byte enables
  output logic             o_cfg_cpl,        // Completion strobe
  output logic      [31:0] o_cfg_rdata,      // Read data
  input  wire logic [4:0]  i_training_state_code,  // From training machine
  input  wire logic        i_partner_widen_capable,
  input  wire logic        i_retrain_request,      // Retrain set by software
  input  wire logic        i_width_done,           // Reconfig finished
  input  wire logic [1:0]  i_width_result,         // Outcome on done
  input  wire logic        i_seq_step,             // Sequence advance
  output logic             o_force_detect,         // One-cycle retrain pulse
  output logic             o_width_start,          // One-cycle reconfig start
  output logic      [15:0] o_seq_value             // Sequence word
);
  // ==========================================================
  // State
  typedef struct packed
  {
    logic [1:0]  outcome;                    // Width reconfig outcome
    logic        partner;                    // Partner widen capable
    logic [4:0]  state_code;                 // Mirrored state code
    pls_rt_type  rt;                         // Retrain sequencer
    logic        cpl;                        // Completion strobe
    logic [31:0] rdata;                      // Read data
    logic        force_det;                  // Detect pulse
    logic        wstart;                     // Reconfig start
    logic        retrain_d;                  // Retrain edge history
  } pls_st_type;
  pls_st_type st_reg;
  pls_st_type st_next;
  // Seed lives on the sticky reset so it survives link resets
  logic [15:0] seed_reg;
  logic [15:0] seed_next;
  logic        seed_load_reg;                // Restart the counter
  logic        seed_load_next;
  logic        wr_state;                     // Write hits state register
  logic        wr_seed;                      // Write hits seed register

  assign wr_state = i_cfg_req && i_cfg_wr && (i_cfg_addr == PLS_OFS_TRAIN_STATE);
  assign wr_seed  = i_cfg_req && i_cfg_wr && (i_cfg_addr == PLS_OFS_SEED);

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    st_next            = st_reg;
    st_next.cpl        = 1'b0;
    st_next.force_det  = 1'b0;
    st_next.wstart     = 1'b0;
    st_next.partner    = i_partner_widen_capable;
    st_next.state_code = i_training_state_code;
    st_next.retrain_d  = i_retrain_request;
    // Start reconfig on retrain request rising edge
    if (i_retrain_request && !st_reg.retrain_d)
    begin
      st_next.wstart  = 1'b1;
      st_next.outcome = PLS_OUTCOME_IDLE;
    end
    else if (i_width_done)
    begin
      st_next.outcome = i_width_result;
    end
    // Config access, completion one cycle later
    if (i_cfg_req)
    begin
      st_next.cpl   = 1'b1;
      st_next.rdata = 32'h0000_0000;
      if (!i_cfg_wr)
      begin
        case (i_cfg_addr)
          PLS_OFS_LINK_STATUS:
          begin
            st_next.rdata[PLS_OUTCOME_LSB +: 2] = st_reg.outcome;
            st_next.rdata[PLS_PARTNER_BIT]      = st_reg.partner;
          end
          PLS_OFS_TRAIN_STATE:
          begin
            // Retrain bit stays zero in read data
            st_next.rdata[4:0] = st_reg.state_code;
          end
          PLS_OFS_SEED:
          begin
            st_next.rdata[15:0] = seed_reg;
          end
          default:
          begin
            st_next.rdata = 32'h0000_0000;           // Unmapped reads zero
          end
        endcase
      end
    end
    // Retrain: completion goes out first, then the detect pulse
    case (st_reg.rt)
      PLS_RT_IDLE:
      begin
        if (wr_state && i_cfg_be[3] && i_cfg_wdata[PLS_RETRAIN_BIT])
          st_next.rt = PLS_RT_ACK;
      end
      PLS_RT_ACK:
      begin
        st_next.rt = PLS_RT_GO;
      end
      PLS_RT_GO:
      begin
        st_next.force_det = 1'b1;
        st_next.rt        = PLS_RT_IDLE;
      end
      default:
      begin
        st_next.rt = PLS_RT_IDLE;
      end
    endcase
  end

  // Seed update, byte lanes honoured
  always_comb
  begin
    seed_next      = seed_reg;
    seed_load_next = 1'b0;
    if (wr_seed)
    begin
      if (i_cfg_be[0])
        seed_next[7:0] = i_cfg_wdata[7:0];
      if (i_cfg_be[1])
        seed_next[15:8] = i_cfg_wdata[15:8];
      seed_load_next = (seed_next != seed_reg);
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      st_reg.outcome    <= PLS_OUTCOME_IDLE;
      st_reg.partner    <= 1'b0;
      st_reg.state_code <= 5'h00;
      st_reg.rt         <= PLS_RT_IDLE;
      st_reg.cpl        <= 1'b0;
      st_reg.rdata      <= 32'h0000_0000;
      st_reg.force_det  <= 1'b0;
      st_reg.wstart     <= 1'b0;
      st_reg.retrain_d  <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Sticky domain: only the power-on reset touches the seed
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst_sticky)
    begin
      seed_reg      <= PLS_SEED_RESET;
      seed_load_reg <= 1'b0;
    end
    else
    begin
      seed_reg      <= seed_next;
      seed_load_reg <= seed_load_next;
    end
  end

  // Sequence counter for crosslink use
  pls_seed_counter u_seq
  (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst_sticky),
    .i_load    (seed_load_reg),
    .i_step    (i_seq_step),
    .i_seed    (seed_reg),
    .o_value   (o_seq_value)
  );

  assign o_cfg_cpl      = st_reg.cpl;
  assign o_cfg_rdata    = st_reg.rdata;
  assign o_force_detect = st_reg.force_det;
  assign o_width_start  = st_reg.wstart;

  // ==========================================================
  // Checks
  property p_retrain_after_cpl;
    @(posedge i_clk_sys) disable iff (i_srst)
      (wr_state && i_cfg_be[3] && i_cfg_wdata[PLS_RETRAIN_BIT] && st_reg.rt == PLS_RT_IDLE)
        |=> o_cfg_cpl && !o_force_detect ##1 !o_force_detect ##1 o_force_detect;
  endproperty
  a_retrain_after_cpl: assert property (p_retrain_after_cpl) else $error("retrain order");

  property p_retrain_reads_zero;
    @(posedge i_clk_sys) disable iff (i_srst)
      o_cfg_cpl |-> !o_cfg_rdata[PLS_RETRAIN_BIT];
  endproperty
  a_retrain_reads_zero: assert property (p_retrain_reads_zero) else $error("bit 31 set");

  property p_state_read;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_cfg_req && !i_cfg_wr && i_cfg_addr == PLS_OFS_TRAIN_STATE)
        |=> o_cfg_rdata[4:0] == $past(st_reg.state_code);
  endproperty
  a_state_read: assert property (p_state_read) else $error("state code mismatch");

  property p_status_reserved;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_cfg_req && !i_cfg_wr && i_cfg_addr == PLS_OFS_LINK_STATUS)
        |=> o_cfg_rdata[31:17] == 15'h0000 && o_cfg_rdata[15:14] == 2'h0
            && o_cfg_rdata[11:0] == 12'h000;
  endproperty
  a_status_reserved: assert property (p_status_reserved) else $error("reserved set");

  property p_outcome_capture;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_width_done && !(i_retrain_request && !st_reg.retrain_d))
        |=> st_reg.outcome == $past(i_width_result);
  endproperty
  a_outcome_capture: assert property (p_outcome_capture) else $error("outcome lost");

  property p_partner_mirror;
    @(posedge i_clk_sys) disable iff (i_srst)
      1'b1 |=> st_reg.partner == $past(i_partner_widen_capable);
  endproperty
  a_partner_mirror: assert property (p_partner_mirror) else $error("partner bit");

  property p_width_start;
    @(posedge i_clk_sys) disable iff (i_srst)
      $rose(i_retrain_request) |=> o_width_start ##1 !o_width_start;
  endproperty
  a_width_start: assert property (p_width_start) else $error("no reconfig start");

  property p_seed_write;
    @(posedge i_clk_sys) disable iff (i_srst_sticky)
      (wr_seed && i_cfg_be[1:0] == 2'h3) |=> seed_reg == $past(i_cfg_wdata[15:0]);
  endproperty
  a_seed_write: assert property (p_seed_write) else $error("seed not stored");

  property p_seed_restart;
    @(posedge i_clk_sys) disable iff (i_srst_sticky)
      (wr_seed && seed_next != seed_reg) |=> ##1 o_seq_value == seed_reg;
  endproperty
  a_seed_restart: assert property (p_seed_restart) else $error("counter not restarted");

  property p_no_spurious_detect;
    @(posedge i_clk_sys) disable iff (i_srst)
      o_force_detect |-> $past(st_reg.rt) == PLS_RT_GO;
  endproperty
  a_no_spurious_detect: assert property (p_no_spurious_detect) else $error("stray detect");
endmodule : pls_regs

// *** testbench/pls_link_partner.sv ***
// Training machine and width logic stand-in facing the register block.
// Assumes the bench picks the state to show and the width outcome.
`timescale 1ns/1ps
module pls_link_partner
  import pls_pkg::*;
#(
  parameter int LAT = 8  // Cycles from width start to done
)
(
  input  wire logic       i_clk_sys,    // Core clock
  input  wire logic       i_srst,       // Sync reset, high
  input  wire logic       i_force,      // Retrain pulse from block
  input  wire logic       i_start,      // Width start pulse from block
  input  wire logic [4:0] i_state_sel,  // State the bench asks for
  input  wire logic [1:0] i_result,     // Outcome to report
  output logic      [4:0] o_state,      // Current training state
  output logic            o_done,       // Width reconfig finished
  output logic      [1:0] o_result      // Outcome, valid with done
);
  logic [4:0] sel_reg;   // Last requested state
  int         wait_reg;  // Countdown to done, 0 when idle
  // ==========================================================
  // State follows the bench, but a retrain pulse wins
  always_ff @(posedge i_clk_sys)
  begin
    sel_reg  <= i_state_sel;
    o_done   <= 1'b0;
    o_result <= ~o_result;  // Only meaningful with done, so keep it moving
    if (i_srst)
    begin
      o_state  <= 5'h00;
      o_result <= 2'h0;
      wait_reg <= 0;
    end
    else
    begin
      if (i_force)
        o_state <= PLS_ST_DET_QUIET;  // Retrain lands in detect
      else if (i_state_sel != sel_reg)
        o_state <= i_state_sel;
      if (i_start)
        wait_reg <= LAT;  // Slow answer so the cleared outcome is visible
      else if (wait_reg == 1)
      begin
        o_done   <= 1'b1;
        o_result <= i_result;
        wait_reg <= 0;
      end
      else if (wait_reg > 1)
        wait_reg <= wait_reg - 1;
    end
  end
endmodule : pls_link_partner

// *** testbench/tb_top.sv ***
// Self-checking bench for the link status register group.
// Assumes the partner stand-in drives the training and width inputs.
`timescale 1ns/1ps
module tb_top
  import pls_pkg::*;
;
  logic        clk, srst, srst_sticky, req, wr, cap, retrain, step;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [3:0]  be;
  logic        cpl, force_det, wstart, wdone;
  logic [4:0]  state_code, state_sel;
  logic [1:0]  wres, result_sel;
  logic [15:0] seqv;
  int          num_errors, n_compared, cyc, cpl_cyc, fd_cyc, ws_cnt;
  localparam logic [4:0] CODES [8] = '{5'h02, 5'h03, 5'h04, 5'h10,
                                       5'h13, 5'h14, 5'h1A, 5'h1B};
  // ==========================================================
  // Design, partner and clock
  pls_regs DUT (.i_clk_sys(clk), .i_srst(srst), .i_srst_sticky(srst_sticky),
    .i_cfg_req(req), .i_cfg_wr(wr), .i_cfg_addr(addr), .i_cfg_wdata(wdata),
    .i_cfg_be(be), .o_cfg_cpl(cpl), .o_cfg_rdata(rdata),
    .i_training_state_code(state_code), .i_partner_widen_capable(cap),
    .i_retrain_request(retrain), .i_width_done(wdone), .i_width_result(wres),
    .i_seq_step(step), .o_force_detect(force_det), .o_width_start(wstart),
    .o_seq_value(seqv));
  pls_link_partner u_partner (.i_clk_sys(clk), .i_srst(srst), .i_force(force_det),
    .i_start(wstart), .i_state_sel(state_sel), .i_result(result_sel),
    .o_state(state_code), .o_done(wdone), .o_result(wres));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================================
  // Event stamps and the hang limit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cpl) cpl_cyc <= cyc;
    if (force_det) fd_cyc <= cyc;
    if (wstart) ws_cnt <= ws_cnt + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One request strobe, then wait a bounded time for the completion
  task automatic cfg(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    req = 1'b1; wr = w; addr = a; wdata = d;
    @(negedge clk);
    req = 1'b0;
    q = 'x;  // Stays unknown if no completion arrives
    repeat (4)
    begin
      if (cpl === 1'b1)
      begin
        q = rdata;
        break;
      end
      @(negedge clk);
    end
  endtask : cfg
  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    cfg(1'b0, a, 32'h0);
    check(what, exp, q);
  endtask : rd
  task automatic finish_test;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  // ==========================================================
  // Main sequence
  initial
  begin
    {req, wr, cap, retrain, step, addr, wdata, state_sel, result_sel} = '0;
    {num_errors, n_compared, cyc, cpl_cyc, fd_cyc, ws_cnt} = '0;
    be = 4'hF; srst = 1'b1; srst_sticky = 1'b1;
    repeat (20) @(negedge clk);
    srst = 1'b0; srst_sticky = 1'b0;
    rd("seed reset", PLS_OFS_SEED, 32'h0000FFFF);
    check("sequence reset", 32'h0000FFFF, {16'h0, seqv});
    rd("status reset", PLS_OFS_LINK_STATUS, 32'h0);
    rd("unmapped read", 12'h53C, 32'h0);
    foreach (CODES[i])
    begin
      state_sel = CODES[i];
      repeat (3) @(negedge clk);
      rd("state code", PLS_OFS_TRAIN_STATE, {27'h0, CODES[i]});
    end
    cap = 1'b1;
    repeat (3) @(negedge clk);
    rd("widen capable", PLS_OFS_LINK_STATUS, 32'h00010000);
    // Retrain with every reserved bit set as well
    cfg(1'b1, PLS_OFS_TRAIN_STATE, 32'hFFFFFFFF);
    repeat (4) @(negedge clk);
    check("retrain after completion", 32'd2, 32'(fd_cyc - cpl_cyc));
    rd("retrain reads zero", PLS_OFS_TRAIN_STATE, 32'h00000002);
    // Each non-idle outcome code in turn, cleared at every new start
    for (int r = 1; r < 4; r++)
    begin
      result_sel = 2'(r);
      retrain = 1'b1;
      repeat (2) @(negedge clk);
      check("width start count", 32'(r), 32'(ws_cnt));
      rd("outcome cleared", PLS_OFS_LINK_STATUS, 32'h00010000);
      repeat (10) @(negedge clk);
      retrain = 1'b0;
      rd("outcome", PLS_OFS_LINK_STATUS, 32'h00010000 | (32'(r) << 12));
    end
    // Seed write reloads the sequence, reserved half ignored
    cfg(1'b1, PLS_OFS_SEED, 32'hFFFF1234);
    @(negedge clk);
    check("sequence reload", 32'h00001234, {16'h0, seqv});
    rd("seed value", PLS_OFS_SEED, 32'h00001234);
    step = 1'b1;
    repeat (5) @(negedge clk);
    step = 1'b0;
    // An unknown sequence word must not count as having moved
    check("sequence moved", 32'h1, {31'h0, (seqv != 16'h1234) === 1'b1});
    cfg(1'b1, PLS_OFS_SEED, 32'h0000BEEF);
    @(negedge clk);
    check("sequence restart", 32'h0000BEEF, {16'h0, seqv});
    // Low byte lane only: the high seed byte must keep its value
    be = 4'h1;
    cfg(1'b1, PLS_OFS_SEED, 32'h00000012);
    be = 4'hF;
    rd("seed byte lane", PLS_OFS_SEED, 32'h0000BE12);
    // Plain reset keeps the sticky seed
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    rd("seed sticky", PLS_OFS_SEED, 32'h0000BE12);
    rd("outcome after reset", PLS_OFS_LINK_STATUS, 32'h00010000);
    finish_test();
  end
endmodule : tb_top
